//--- hw/itx_defines.svh
// Constants for the instruction timing and extension word decoder
// Behaviour
// - Jumps are one word and always take two cycles, taken or not.
// - Original core: marked single-operand and SP-indexed forms take 5.
// - Register dst: 1 from register, 2 indirect/immediate, 3 memory.
// - PC destination: 2 cycles from register source, otherwise 3.
// - Memory destination: 4/5/6 cycles; copy, bit-test, compare one fewer.
// - Double-op length is one word plus one per memory/immediate operand.
// - Most extended instructions carry one prefix word for 20-bit access.
// - After an extension word, addresses, indexes and immediates are 20 bits.
// - Some extended instructions run without any prefix word.
// - Two extension formats: register mode and all other modes.
// - Bits 15:11 equal to 00011 mark an extension word, 1800h to 1FFFh.
// - Length bit with byte/word bit: reserved, 20-bit, 16-bit, 8-bit.
// - Count-source 0: bits 3:0 hold repeat count minus one.
// - Count-source 1: bits 3:0 name a register with low nibble count-1.
// - Jump offset is doubled, sign-extended to 20 bits, added to PC.
// - Non-register extension gives source and destination bits 19:16.
`ifndef ITX_DEFINES_SVH
`define ITX_DEFINES_SVH
`define ITX_EXT_OPC 5'h03
`define ITX_EXT_OPC_HI 15
`define ITX_EXT_OPC_LO 11
`define ITX_EXT_ZC_BIT 8
`define ITX_EXT_CNTSRC_BIT 7
`define ITX_EXT_AL_BIT 6
`define ITX_EXT_SRC_HI 10
`define ITX_EXT_SRC_LO 7
`define ITX_EXT_DST_HI 3
`define ITX_EXT_DST_LO 0
`define ITX_JMP_OPC 3'h1
`define ITX_JMP_CYC 3'h2
`define ITX_LEGACY_CYC 3'h5
`endif

//--- hw/itx_pkg.sv
// Types shared by the instruction timing and extension word decoder
package itx_pkg;
   typedef enum logic [1:0] {
      ITX_RES = 2'b00,
      ITX_ADDR = 2'b01,
      ITX_WORD = 2'b10,
      ITX_BYTE = 2'b11
   } itx_len_e;
   typedef enum logic [1:0] {
      ITX_FMT_JUMP = 2'b00,
      ITX_FMT_DOUBLE = 2'b01,
      ITX_FMT_SINGLE = 2'b10,
      ITX_FMT_OTHER = 2'b11
   } itx_fmt_e;
endpackage : itx_pkg

//--- hw/itx_timing.sv
// Cycle count and length table for jumps and double-operand instructions
`include "itx_defines.svh"
module itx_timing
   import itx_pkg::*;
(
   // Decoded instruction fields
   input wire itx_pkg::itx_fmt_e fmt,
   input wire logic [1:0] src_mode,
   input wire logic [3:0] src_reg,
   input wire logic dst_mode,
   input wire logic [3:0] dst_reg,
   input wire logic [3:0] opcode,
   // Results
   output logic [2:0] cycles,
   output logic [1:0] words
);
   // Immediate is @PC+; absolute and symbolic are indexed forms
   function automatic logic src_is_mem(input logic [1:0] m);
      return m == 2'b01;
   endfunction : src_is_mem

   logic src_reg_mode;
   logic src_indir;
   logic short_op;
   logic src_imm;
   always_comb begin
      src_reg_mode = (src_mode == 2'b00);
      src_indir = src_mode[1];
      src_imm = (src_mode == 2'b11) && (src_reg == 4'h0);
      // Copy, bit-test and compare opcodes
      short_op = (opcode == 4'h4) || (opcode == 4'hb) || (opcode == 4'h9);
      cycles = 3'h1;
      words = 2'h1;
      unique case (fmt)
         ITX_FMT_JUMP: begin
            cycles = `ITX_JMP_CYC;
            words = 2'h1;
         end
         ITX_FMT_DOUBLE: begin
            if (!dst_mode && dst_reg != 4'h0) begin
               cycles = src_reg_mode ? 3'h1
                        : (src_indir ? 3'h2 : 3'h3);
            end else if (!dst_mode) begin
               cycles = src_reg_mode ? 3'h2 : 3'h3;
            end else begin
               cycles = src_reg_mode ? 3'h4
                        : (src_indir ? 3'h5 : 3'h6);
               if (short_op) begin
                  cycles = cycles - 3'h1;
               end
            end
            // One word plus one per immediate or indexed operand
            words = 2'h1 + {1'b0, src_is_mem(src_mode) | src_imm}
                    + {1'b0, dst_mode};
         end
         default: begin
            cycles = 3'h1;
            words = 2'h1;
         end
      endcase
   end
endmodule : itx_timing

//--- hw/itx_decoder.sv
// Instruction decoder slice: timing, jump target and extension word state
`include "itx_defines.svh"
module itx_decoder
   import itx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Instruction word stream
   input wire logic word_valid,
   input wire logic [15:0] word,
   input wire logic [19:0] pc,
   input wire logic legacy_core,
   // Register file read for register-sourced repeat counts
   output logic [3:0] cnt_reg_sel,
   input wire logic [3:0] cnt_reg_low,
   // Instruction results
   output logic instr_valid,
   output logic [2:0] instr_cycles,
   output logic [1:0] instr_words,
   output logic [19:0] jump_target,
   output logic ext_active,
   output logic ext_reg_fmt,
   output logic ext_wide,
   output itx_pkg::itx_len_e data_len,
   output logic [3:0] rep_count_m1,
   output logic carry_zero,
   output logic [3:0] src_hi,
   output logic [3:0] dst_hi
);
   import itx_pkg::*;

   // Bits 15:11 select the prefix opcode
   function automatic logic is_ext(input logic [15:0] w);
      return w[`ITX_EXT_OPC_HI:`ITX_EXT_OPC_LO] == `ITX_EXT_OPC;
   endfunction : is_ext

   function automatic itx_fmt_e fmt_of(input logic [15:0] w);
      if (w[15:13] == `ITX_JMP_OPC) begin
         return ITX_FMT_JUMP;
      end
      if (w[15:12] >= 4'h4) begin
         return ITX_FMT_DOUBLE;
      end
      if (w[15:10] == 6'h04) begin
         return ITX_FMT_SINGLE;
      end
      return ITX_FMT_OTHER;
   endfunction : fmt_of

   logic word_ext;
   itx_fmt_e cur_fmt;
   logic [2:0] tab_cycles;
   logic [1:0] tab_words;
   logic [15:0] ext_word;
   logic pend;
   logic next_reg_fmt;
   logic [2:0] next_cycles;

   assign word_ext = word_valid && is_ext(word);
   assign cur_fmt = fmt_of(word);
   assign cnt_reg_sel = ext_word[3:0];

   itx_timing u_timing (
      .fmt(cur_fmt),
      .src_mode(word[5:4]),
      .src_reg(word[11:8]),
      .dst_mode(word[7]),
      .dst_reg(word[3:0]),
      .opcode(word[15:12]),
      .cycles(tab_cycles),
      .words(tab_words)
   );

   // Register-mode format: both operands in registers for double operand
   always_comb begin
      next_reg_fmt = 1'b0;
      if (cur_fmt == ITX_FMT_DOUBLE) begin
         next_reg_fmt = (word[5:4] == 2'b00) && !word[7];
      end else if (cur_fmt == ITX_FMT_SINGLE) begin
         next_reg_fmt = (word[5:4] == 2'b00);
      end
   end

   // The original core is slower on marked single-operand and SP-indexed forms
   always_comb begin
      next_cycles = tab_cycles;
      if (legacy_core && cur_fmt == ITX_FMT_SINGLE &&
          (word[5:4] != 2'b00 || word[3:0] == 4'h1)) begin
         next_cycles = `ITX_LEGACY_CYC;
      end
   end

   // Prefix capture; a prefix applies only to the next word
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pend <= 1'b0;
         ext_word <= 16'h0000;
      end else if (word_ext) begin
         pend <= 1'b1;
         ext_word <= word;
      end else if (word_valid) begin
         pend <= 1'b0;
      end
   end

   // Instruction outputs; data stays registered for a clean timing path
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         instr_valid <= 1'b0;
         instr_cycles <= 3'h0;
         instr_words <= 2'h0;
         jump_target <= 20'h00000;
         ext_active <= 1'b0;
         ext_reg_fmt <= 1'b0;
         ext_wide <= 1'b0;
         data_len <= ITX_WORD;
         rep_count_m1 <= 4'h0;
         carry_zero <= 1'b0;
         src_hi <= 4'h0;
         dst_hi <= 4'h0;
      end else begin
         instr_valid <= word_valid && !word_ext;
         if (word_valid && !word_ext) begin
            instr_cycles <= next_cycles;
            instr_words <= tab_words;
            // Doubled offset, sign-extended to 20 bits
            jump_target <= pc + {{9{word[9]}}, word[9:0], 1'b0};
            ext_active <= pend;
            ext_wide <= pend;
            ext_reg_fmt <= pend && next_reg_fmt;
            // Prefix bits 5:4 are never looked at
            data_len <= itx_len_e'(pend ? {ext_word[`ITX_EXT_AL_BIT], word[6]}
                                        : {1'b1, word[6]});
            rep_count_m1 <= 4'h0;
            carry_zero <= 1'b0;
            src_hi <= 4'h0;
            dst_hi <= 4'h0;
            if (pend && next_reg_fmt) begin
               rep_count_m1 <= ext_word[`ITX_EXT_CNTSRC_BIT] ? cnt_reg_low
                               : ext_word[3:0];
               carry_zero <= ext_word[`ITX_EXT_ZC_BIT];
            end else if (pend) begin
               src_hi <= ext_word[`ITX_EXT_SRC_HI:
                                  `ITX_EXT_SRC_LO];
               dst_hi <= ext_word[`ITX_EXT_DST_HI:
                                  `ITX_EXT_DST_LO];
            end
         end
      end
   end

   a_jump_cycles: assert property (@(posedge clk) disable iff (!rstn)
      word_valid && !word_ext && cur_fmt == ITX_FMT_JUMP
      |=> instr_cycles == 3'h2 && instr_words == 2'h1)
      else $error("jump timing wrong");
   a_prefix_no_instr: assert property (@(posedge clk) disable iff (!rstn)
      word_ext |=> !instr_valid)
      else $error("prefix taken as instruction");
   a_prefix_wide: assert property (@(posedge clk) disable iff (!rstn)
      word_ext ##1 (word_valid && !word_ext) |=> ext_wide)
      else $error("prefix not widening");
   a_plain_narrow: assert property (@(posedge clk) disable iff (!rstn)
      !pend && word_valid && !word_ext |=> !ext_active)
      else $error("stale prefix applied");
   a_reg_count: assert property (@(posedge clk) disable iff (!rstn)
      pend && next_reg_fmt && word_valid && !word_ext
      && !ext_word[`ITX_EXT_CNTSRC_BIT]
      |=> rep_count_m1 == $past(ext_word[3:0]))
      else $error("repeat count wrong");
   a_jump_target: assert property (@(posedge clk) disable iff (!rstn)
      word_valid && !word_ext
      |=> jump_target == $past(pc) + {{9{$past(word[9])}},
                                    $past(word[9:0]), 1'b0})
      else $error("jump target wrong");
   a_dbl_words: assert property (@(posedge clk) disable iff (!rstn)
      word_valid && cur_fmt == ITX_FMT_DOUBLE && word[5:4] == 2'b00
      && !word[7] |=> instr_words == 2'h1)
      else $error("length wrong");
   a_len_plain: assert property (@(posedge clk) disable iff (!rstn)
      !pend && word_valid && !word_ext |=> data_len[1])
      else $error("plain length wrong");

   // Checks per table entry; each one needs its own stimulus to fire
   logic acc_word;
   assign acc_word = word_valid && !word_ext;

   // Register source into a general register is the fastest form
   a_reg_dst_one: assert property (@(posedge clk) disable iff (!rstn)
      acc_word && cur_fmt == ITX_FMT_DOUBLE && !word[7]
      && word[3:0] != 4'h0 && word[5:4] == 2'b00
      |=> instr_cycles == 3'h1)
      else $error("register source timing wrong");

   // Indirect, autoincrement and immediate sources cost one more read
   a_reg_dst_two: assert property (@(posedge clk) disable iff (!rstn)
      acc_word && cur_fmt == ITX_FMT_DOUBLE && !word[7]
      && word[3:0] != 4'h0 && word[5]
      |=> instr_cycles == 3'h2)
      else $error("indirect source timing wrong");

   // Indexed source needs the extra index word fetched first
   a_reg_dst_three: assert property (@(posedge clk) disable iff (!rstn)
      acc_word && cur_fmt == ITX_FMT_DOUBLE && !word[7]
      && word[3:0] != 4'h0 && word[5:4] == 2'b01
      |=> instr_cycles == 3'h3)
      else $error("indexed source timing wrong");

   // Writing the program counter from a register costs a refetch
   a_pc_dst_reg: assert property (@(posedge clk) disable iff (!rstn)
      acc_word && cur_fmt == ITX_FMT_DOUBLE && !word[7]
      && word[3:0] == 4'h0 && word[5:4] == 2'b00
      |=> instr_cycles == 3'h2)
      else $error("branch from register timing wrong");

   // Any other source into the program counter takes three
   a_pc_dst_other: assert property (@(posedge clk) disable iff (!rstn)
      acc_word && cur_fmt == ITX_FMT_DOUBLE && !word[7]
      && word[3:0] == 4'h0 && word[5:4] != 2'b00
      |=> instr_cycles == 3'h3)
      else $error("branch from memory timing wrong");

   // Add with register source into memory has the full write-back
   a_mem_dst_add: assert property (@(posedge clk) disable iff (!rstn)
      acc_word && cur_fmt == ITX_FMT_DOUBLE && word[7]
      && word[15:12] == 4'h5 && word[5:4] == 2'b00
      |=> instr_cycles == 3'h4)
      else $error("memory destination timing wrong");

   // A copy skips the destination read, so one cycle less
   a_mem_dst_copy: assert property (@(posedge clk) disable iff (!rstn)
      acc_word && cur_fmt == ITX_FMT_DOUBLE && word[7]
      && word[15:12] == 4'h4 && word[5:4] == 2'b00
      |=> instr_cycles == 3'h3)
      else $error("copy to memory timing wrong");

   // Memory destinations always span three to six cycles
   a_mem_dst_range: assert property (@(posedge clk) disable iff (!rstn)
      acc_word && cur_fmt == ITX_FMT_DOUBLE && word[7]
      |=> instr_cycles inside {[3'h3:3'h6]})
      else $error("memory destination out of range");

   // An indexed destination always brings its own index word
   a_mem_dst_words: assert property (@(posedge clk) disable iff (!rstn)
      acc_word && cur_fmt == ITX_FMT_DOUBLE && word[7]
      |=> instr_words >= 2'h2)
      else $error("memory destination length wrong");

   // Immediate source into a register carries one constant word
   a_imm_words: assert property (@(posedge clk) disable iff (!rstn)
      acc_word && cur_fmt == ITX_FMT_DOUBLE && !word[7]
      && word[5:4] == 2'b11 && word[11:8] == 4'h0
      |=> instr_words == 2'h2)
      else $error("immediate length wrong");

   // Original core keeps its slower single-operand memory forms
   a_legacy_five: assert property (@(posedge clk) disable iff (!rstn)
      acc_word && legacy_core && cur_fmt == ITX_FMT_SINGLE
      && word[5:4] != 2'b00
      |=> instr_cycles == 3'h5)
      else $error("original core timing wrong");

   // Every accepted instruction word yields exactly one result pulse
   a_valid_pulse: assert property (@(posedge clk) disable iff (!rstn)
      acc_word |=> instr_valid)
      else $error("instruction lost");

   // Format choice follows the operand modes of the prefixed word
   a_reg_fmt_flag: assert property (@(posedge clk) disable iff (!rstn)
      pend && acc_word
      |=> ext_reg_fmt == $past(next_reg_fmt))
      else $error("extension format wrong");

   // Prefixed length comes from the prefix bit and the byte bit
   a_len_prefixed: assert property (@(posedge clk) disable iff (!rstn)
      pend && acc_word
      |=> data_len == $past({ext_word[`ITX_EXT_AL_BIT], word[6]}))
      else $error("prefixed length wrong");

   // Register-sourced count uses the value read in the taking cycle
   a_reg_count_src: assert property (@(posedge clk) disable iff (!rstn)
      pend && next_reg_fmt && acc_word && ext_word[`ITX_EXT_CNTSRC_BIT]
      |=> rep_count_m1 == $past(cnt_reg_low))
      else $error("register repeat count wrong");

   // Carry handling of repeated operations follows the prefix bit
   a_carry_zero: assert property (@(posedge clk) disable iff (!rstn)
      pend && next_reg_fmt && acc_word
      |=> carry_zero == $past(ext_word[`ITX_EXT_ZC_BIT]))
      else $error("carry select wrong");

   // Upper address nibbles come straight from the memory-mode prefix
   a_prefix_hi: assert property (@(posedge clk) disable iff (!rstn)
      pend && !next_reg_fmt && acc_word
      |=> src_hi == $past(ext_word[`ITX_EXT_SRC_HI:`ITX_EXT_SRC_LO])
      && dst_hi == $past(ext_word[`ITX_EXT_DST_HI:`ITX_EXT_DST_LO]))
      else $error("upper address bits wrong");

   c_prefixed: cover property (@(posedge clk) disable iff (!rstn)
      word_ext ##1 (word_valid && !word_ext));
   c_jump: cover property (@(posedge clk) disable iff (!rstn)
      word_valid && cur_fmt == ITX_FMT_JUMP);
   c_repeat_reg: cover property (@(posedge clk) disable iff (!rstn)
      pend && next_reg_fmt && ext_word[`ITX_EXT_CNTSRC_BIT] && word_valid);
   c_legacy: cover property (@(posedge clk) disable iff (!rstn)
      acc_word && legacy_core && cur_fmt == ITX_FMT_SINGLE);
   c_mem_dst: cover property (@(posedge clk) disable iff (!rstn)
      acc_word && cur_fmt == ITX_FMT_DOUBLE && word[7]);
endmodule : itx_decoder

//--- tb/testbench.sv
// Self-checking bench for the instruction timing and extension decoder
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import itx_pkg::*;
   logic clk, rstn, word_valid, legacy_core;
   logic [15:0] word, w, pw;
   logic [19:0] pc, jump_target, tgt;
   logic [3:0] cnt_reg_sel, cnt_reg_low, rep_count_m1, src_hi, dst_hi;
   logic instr_valid, ext_active, ext_reg_fmt, ext_wide, carry_zero, rf;
   logic [2:0] instr_cycles;
   logic [1:0] instr_words;
   itx_len_e data_len;
   logic [31:0] seed = 32'ha282;
   logic [31:0] r;
   logic [3:0] regs [16];
   int n_fail = 0;
   int comparisons = 0;
   int cyc = 0;

   // Register file stand-in answers the count-register read at once
   assign cnt_reg_low = regs[cnt_reg_sel];

   itx_decoder dut (.clk, .rstn, .word_valid, .word, .pc, .legacy_core,
      .cnt_reg_sel, .cnt_reg_low, .instr_valid, .instr_cycles,
      .instr_words, .jump_target, .ext_active, .ext_reg_fmt, .ext_wide,
      .data_len, .rep_count_m1, .carry_zero, .src_hi, .dst_hi);

   // Free-running clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Hang guard: the whole sequence needs well under 1000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         end_of_test();
      end
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Drive just after an edge; return just after the edge that takes it
   task automatic step(input logic v, input logic [15:0] x);
      word_valid = v;
      word = x;
      @(posedge clk);
      #1;
   endtask : step

   // Reference cycle count; dk is 0 register, 1 PC, 2 memory destination
   function automatic int exp_cyc(int opc, int as_m, int dk);
      int c;
      if (dk == 0)
         c = (as_m == 0) ? 1 : (as_m == 1) ? 3 : 2;
      else if (dk == 1)
         c = (as_m == 0) ? 2 : 3;
      else begin
         c = (as_m == 0) ? 4 : (as_m == 1) ? 6 : 5;
         // Copy, bit-test and compare skip the write-back
         if (opc == 4 || opc == 9 || opc == 11)
            c--;
      end
      return c;
   endfunction : exp_cyc

   // Source kinds: register, indirect, autoincrement, immediate, indexed
   function automatic logic [15:0] dbl(int opc, int sk, int dk);
      logic [31:0] q;
      logic [3:0] sreg, dreg;
      logic [1:0] as_m;
      q = rnd();
      // Registers 2 and 3 avoided: they double as constant generators
      sreg = (sk == 3) ? 4'h0 : 4'h4 + 4'(q[7:0] % 12);
      as_m = (sk == 0) ? 2'h0 : (sk == 1) ? 2'h2 : (sk == 4) ? 2'h1 : 2'h3;
      dreg = (dk == 1) ? 4'h0 : 4'h4 + 4'(q[15:8] % 12);
      return {4'(opc), sreg, dk == 2, q[16], as_m, dreg};
   endfunction : dbl

   task automatic check_plain(input logic [15:0] x);
      int nw;
      int dk;
      nw = 1 + int'(x[5:4] == 2'h1) + int'(x[7]);
      nw += int'(x[5:4] == 2'h3 && x[11:8] == 4'h0);
      dk = x[7] ? 2 : (x[3:0] == 4'h0) ? 1 : 0;
      chk(instr_valid, 1);
      chk(instr_cycles,
          exp_cyc(x[15:12], x[5:4], dk));
      chk(instr_words, nw);
      chk(data_len, {1'b1, x[6]});
      chk({ext_active, ext_wide}, 0);
   endtask : check_plain

   task automatic end_of_test();
      if (n_fail == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test

   // Main sequence
   initial begin
      rstn = 1'b0;
      word_valid = 1'b0;
      word = 16'h0000;
      pc = 20'h00000;
      legacy_core = 1'b0;
      for (int k = 0; k < 16; k++) begin
         r = rnd();
         regs[k] = r[3:0];
      end
      repeat (5) @(posedge clk);
      chk(instr_valid, 0);
      chk(data_len, ITX_WORD);
      #1 rstn = 1'b1;
      // All eight conditions, offset 0 and the most negative offset
      for (int i = 0; i < 16; i++) begin
         r = rnd();
         w = {3'b001, 3'(i), (i == 0) ? 10'h000 : (i == 1) ? 10'h200 : r[9:0]};
         pc = r[31:12];
         tgt = pc + {{9{w[9]}}, w[9:0], 1'b0};
         step(1'b1, w);
         chk(instr_cycles, 2);
         chk(instr_words, 1);
         chk(jump_target, tgt);
      end
      step(1'b0, 16'h0000);
      chk(instr_valid, 0);
      chk(instr_cycles, 2);
      // Every double-operand opcode against every source and destination kind
      for (int opc = 4; opc < 16; opc++)
         for (int sk = 0; sk < 5; sk++)
            for (int dk = 0; dk < 3; dk++) begin
               w = dbl(opc, sk, dk);
               step(1'b1, w);
               check_plain(w);
            end
      // Prefix, its instruction, then the same word without a prefix
      for (int i = 0; i < 40; i++) begin
         r = rnd();
         pw = {5'h03, (i == 0) ? 11'h000 : (i == 1) ? 11'h7ff : r[10:0]};
         w = dbl(4 + rnd() % 12, rnd() % 5, rnd() % 3);
         step(1'b1, pw);
         chk(instr_valid, 0);
         chk(cnt_reg_sel, pw[3:0]);
         step(1'b1, w);
         rf = (w[5:4] == 2'h0) && !w[7];
         chk({ext_active, ext_wide, ext_reg_fmt},
             {2'b11, rf});
         chk(data_len, {pw[6], w[6]});
         if (rf) begin
            chk(rep_count_m1,
                pw[7] ? regs[pw[3:0]] : pw[3:0]);
            chk(carry_zero, pw[8]);
         end else
            chk({src_hi, dst_hi}, {pw[10:7], pw[3:0]});
         step(1'b1, w);
         check_plain(w);
      end
      // Original core: indexed on the stack pointer takes five cycles
      legacy_core = 1'b1;
      step(1'b1, 16'h1211);
      chk(instr_cycles, 5);
      legacy_core = 1'b0;
      step(1'b0, 16'h0000);
      end_of_test();
   end
endmodule : testbench
